//--- hw/dbrd_pkg.sv
package dbrd_pkg;
	localparam int DBRD_DW = 8;
	localparam int DBRD_AW = 8;
	localparam logic [7:0] RAM_FIRST = 8'h00;
	localparam logic [7:0] RAM_TOP = 8'hff;
	localparam logic [7:0] SP_RST = 8'h00;
	localparam logic [7:0] SP_STEP = 8'h01;
	localparam logic [7:0] FLAG_RST = 8'h00;
	localparam logic [7:0] DATA_ZERO = 8'h00;
	localparam int FLAG_BANK_BIT = 4;
	localparam logic BANK0 = 1'b0;
	localparam logic [7:0] MIRROR_LO = 8'h71;
	localparam logic [7:0] MIRROR_HI = 8'h9f;
	localparam logic [7:0] PORT0_PIN_DATA = 8'h00;
	localparam logic [7:0] PORT0_IRQ_ENABLE = 8'h01;
	localparam logic [7:0] PORT1_PIN_DATA = 8'h04;
	localparam logic [7:0] PORT1_IRQ_ENABLE = 8'h05;
	localparam logic [7:0] PORT1_GLOBAL_SELECT = 8'h06;
	localparam logic [7:0] PORT2_PIN_DATA = 8'h08;
	localparam logic [7:0] PORT2_IRQ_ENABLE = 8'h09;
	localparam logic [7:0] PORT2_GLOBAL_SELECT = 8'h0a;
	localparam logic [7:0] PORT3_IRQ_ENABLE = 8'h0d;
	localparam logic [7:0] PORT3_GLOBAL_SELECT = 8'h0e;
	localparam logic [7:0] PORT4_PIN_DATA = 8'h10;
	localparam logic [7:0] PORT4_IRQ_ENABLE = 8'h11;
	localparam logic [7:0] PORT5_PIN_DATA = 8'h14;
	localparam logic [7:0] PORT5_IRQ_ENABLE = 8'h15;
	localparam logic [7:0] PORT5_GLOBAL_SELECT = 8'h16;
	localparam logic [7:0] ANALOG_COL0_BLK10_CTRL1 = 8'h81;
	localparam logic [7:0] ANALOG_COL0_BLK10_CTRL2 = 8'h82;
	localparam logic [7:0] ANALOG_COL1_BLK11_CTRL1 = 8'h85;
	localparam logic [7:0] ANALOG_COL1_BLK11_CTRL2 = 8'h86;
	localparam logic [7:0] ANALOG_COL2_BLK12_CTRL2 = 8'h8a;
	localparam logic [7:0] ANALOG_COL0_BLK20_CTRL1 = 8'h91;
	localparam logic [7:0] ANALOG_COL0_BLK20_CTRL2 = 8'h92;
	localparam logic [7:0] ANALOG_COL1_BLK21_CTRL1 = 8'h95;
	localparam logic [7:0] ANALOG_COL1_BLK21_CTRL2 = 8'h96;
	localparam logic [7:0] ANALOG_COL1_BLK21_CTRL3 = 8'h97;
	localparam logic [7:0] ANALOG_COL2_BLK22_CTRL0 = 8'h98;
	localparam logic [7:0] ANALOG_COL2_BLK22_CTRL1 = 8'h99;

	function automatic logic dbrd_known0(input logic [7:0] a);
		unique case (a)
			PORT0_PIN_DATA, PORT0_IRQ_ENABLE, PORT1_PIN_DATA,
			PORT1_IRQ_ENABLE, PORT1_GLOBAL_SELECT, PORT2_PIN_DATA,
			PORT2_IRQ_ENABLE, PORT2_GLOBAL_SELECT, PORT3_IRQ_ENABLE,
			PORT3_GLOBAL_SELECT, PORT4_PIN_DATA, PORT4_IRQ_ENABLE,
			PORT5_PIN_DATA, PORT5_IRQ_ENABLE, PORT5_GLOBAL_SELECT,
			ANALOG_COL0_BLK10_CTRL1, ANALOG_COL0_BLK10_CTRL2,
			ANALOG_COL1_BLK11_CTRL1, ANALOG_COL1_BLK11_CTRL2,
			ANALOG_COL2_BLK12_CTRL2, ANALOG_COL0_BLK20_CTRL1,
			ANALOG_COL0_BLK20_CTRL2, ANALOG_COL1_BLK21_CTRL1,
			ANALOG_COL1_BLK21_CTRL2, ANALOG_COL1_BLK21_CTRL3,
			ANALOG_COL2_BLK22_CTRL0, ANALOG_COL2_BLK22_CTRL1: begin
				return 1'b1;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction : dbrd_known0
endpackage : dbrd_pkg

//--- hw/dbrd_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dbrd_mem_if #(parameter int AW = 8, parameter int DW = 8);
	logic en;
	logic we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport ctrl (output en, output we, output addr, output wdata, input rdata);
	modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : dbrd_mem_if
`default_nettype wire

//--- hw/dbrd_ram.sv
`timescale 1ns/100ps
`default_nettype none
module dbrd_ram #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	dbrd_mem_if.mem m
);
	logic [DW-1:0] store [2**AW];
	logic [DW-1:0] rdata_r;

	// The array has no reset, so it maps onto plain RAM cells.
	always_ff @(posedge clk_i) begin
		if (m.en && m.we) begin
			store[m.addr] <= m.wdata;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_r <= '0;
		end else if (m.en && !m.we) begin
			rdata_r <= store[m.addr];
		end
	end

	assign m.rdata = rdata_r;
endmodule : dbrd_ram
`default_nettype wire

//--- hw/dbrd_top.sv
// Functional notes
// - Stack pointer increments on every push made without a pointer load.
// - Push past top wraps pointer to zero.
// - RAM space spans whole eight-bit address range.
// - Two register banks, 256 addresses each.
// - Flag bank bit steers register accesses.
// - Mirrored range reaches bank 0 always.
`timescale 1ns/100ps
`default_nettype none
module dbrd_top (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic FLAG_WE_I,
	input wire logic [dbrd_pkg::DBRD_DW-1:0] FLAG_WDATA_I,
	output logic [dbrd_pkg::DBRD_DW-1:0] FLAG_O,
	input wire logic SP_WE_I,
	input wire logic [dbrd_pkg::DBRD_AW-1:0] SP_WDATA_I,
	output logic [dbrd_pkg::DBRD_AW-1:0] SP_O,
	input wire logic PUSH_I,
	input wire logic [dbrd_pkg::DBRD_DW-1:0] PUSH_DATA_I,
	input wire logic POP_I,
	input wire logic RAM_WE_I,
	input wire logic RAM_RE_I,
	input wire logic [dbrd_pkg::DBRD_AW-1:0] RAM_ADDR_I,
	input wire logic [dbrd_pkg::DBRD_DW-1:0] RAM_WDATA_I,
	output logic [dbrd_pkg::DBRD_DW-1:0] MEM_RDATA_O,
	output logic MEM_VALID_O,
	input wire logic REG_WE_I,
	input wire logic REG_RE_I,
	input wire logic [dbrd_pkg::DBRD_AW-1:0] REG_ADDR_I,
	input wire logic [dbrd_pkg::DBRD_DW-1:0] REG_WDATA_I,
	output logic [dbrd_pkg::DBRD_DW-1:0] REG_RDATA_O,
	output logic REG_VALID_O,
	output logic PER_BANK_O,
	output logic [dbrd_pkg::DBRD_AW-1:0] PER_ADDR_O,
	output logic PER_WE_O,
	output logic PER_RE_O,
	output logic [dbrd_pkg::DBRD_DW-1:0] PER_WDATA_O,
	output logic PER_KNOWN_O,
	input wire logic [dbrd_pkg::DBRD_DW-1:0] PER_RDATA_I
);
	import dbrd_pkg::*;

	typedef struct packed {
		logic [DBRD_AW-1:0] sp;
		logic [DBRD_DW-1:0] flag;
		logic mem_valid;
		logic per_bank;
		logic [DBRD_AW-1:0] per_addr;
		logic per_we;
		logic per_re;
		logic [DBRD_DW-1:0] per_wdata;
		logic per_known;
		logic [DBRD_DW-1:0] reg_rdata;
		logic reg_valid;
	} dbrd_state_t;

	dbrd_state_t q_r;
	dbrd_state_t q_nxt;

	logic bank_sel;
	logic in_mirror;
	logic eff_bank;
	logic reg_req;

	dbrd_mem_if #(.AW(DBRD_AW), .DW(DBRD_DW)) mp ();

	dbrd_ram #(
		.AW(DBRD_AW),
		.DW(DBRD_DW)
	) u_ram (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.m(mp.mem)
	);

	// Bank decode uses the flag value held before this cycle's flag write.
	always_comb begin
		bank_sel = q_r.flag[FLAG_BANK_BIT];
		in_mirror = (REG_ADDR_I >= MIRROR_LO) && (REG_ADDR_I <= MIRROR_HI);
		eff_bank = in_mirror ? BANK0 : bank_sel;
		reg_req = REG_WE_I || REG_RE_I;
	end

	// One RAM port is shared: pointer load, then push, pop, write, read.
	always_comb begin
		q_nxt = q_r;
		q_nxt.mem_valid = 1'b0;
		mp.en = 1'b0;
		mp.we = 1'b0;
		mp.addr = RAM_FIRST;
		mp.wdata = DATA_ZERO;
		if (FLAG_WE_I) begin
			q_nxt.flag = FLAG_WDATA_I;
		end
		if (SP_WE_I) begin
			q_nxt.sp = SP_WDATA_I;
		end else if (PUSH_I) begin
			mp.en = 1'b1;
			mp.we = 1'b1;
			mp.addr = q_r.sp;
			mp.wdata = PUSH_DATA_I;
			// Eight-bit add rolls the top location over to the first one.
			q_nxt.sp = q_r.sp + SP_STEP;
		end else if (POP_I) begin
			mp.en = 1'b1;
			mp.addr = q_r.sp - SP_STEP;
			q_nxt.sp = q_r.sp - SP_STEP;
			q_nxt.mem_valid = 1'b1;
		end else if (RAM_WE_I) begin
			mp.en = 1'b1;
			mp.we = 1'b1;
			mp.addr = RAM_ADDR_I;
			mp.wdata = RAM_WDATA_I;
		end else if (RAM_RE_I) begin
			mp.en = 1'b1;
			mp.addr = RAM_ADDR_I;
			q_nxt.mem_valid = 1'b1;
		end
		// Register request is presented to the peripherals for one cycle.
		q_nxt.per_we = REG_WE_I;
		q_nxt.per_re = REG_RE_I && !REG_WE_I;
		if (reg_req) begin
			q_nxt.per_bank = eff_bank;
			q_nxt.per_addr = REG_ADDR_I;
			q_nxt.per_wdata = REG_WE_I ? REG_WDATA_I : DATA_ZERO;
			q_nxt.per_known = (eff_bank == BANK0) && dbrd_known0(REG_ADDR_I);
		end
		q_nxt.reg_valid = q_r.per_re;
		if (q_r.per_re) begin
			q_nxt.reg_rdata = PER_RDATA_I;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			q_r.sp <= SP_RST;
			q_r.flag <= FLAG_RST;
			q_r.mem_valid <= 1'b0;
			q_r.per_bank <= BANK0;
			q_r.per_addr <= RAM_FIRST;
			q_r.per_we <= 1'b0;
			q_r.per_re <= 1'b0;
			q_r.per_wdata <= DATA_ZERO;
			q_r.per_known <= 1'b0;
			q_r.reg_rdata <= DATA_ZERO;
			q_r.reg_valid <= 1'b0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign FLAG_O = q_r.flag;
	assign SP_O = q_r.sp;
	assign MEM_RDATA_O = mp.rdata;
	assign MEM_VALID_O = q_r.mem_valid;
	assign REG_RDATA_O = q_r.reg_rdata;
	assign REG_VALID_O = q_r.reg_valid;
	assign PER_BANK_O = q_r.per_bank;
	assign PER_ADDR_O = q_r.per_addr;
	assign PER_WE_O = q_r.per_we;
	assign PER_RE_O = q_r.per_re;
	assign PER_WDATA_O = q_r.per_wdata;
	assign PER_KNOWN_O = q_r.per_known;

	// Checks.

	logic boot_r;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			boot_r <= 1'b1;
		end else begin
			boot_r <= 1'b0;
		end
	end

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_B_I);

	sequence s_push;
		PUSH_I && !SP_WE_I;
	endsequence

	sequence s_pop;
		POP_I && !PUSH_I && !SP_WE_I;
	endsequence

	sequence s_read_any;
		REG_RE_I && !REG_WE_I;
	endsequence

	push_advance_a: assert property (
		s_push |=> SP_O == 8'($past(SP_O) + SP_STEP)
	) else $error("stack pointer did not step up on push");

	sp_wrap_a: assert property (
		s_push and (SP_O == RAM_TOP) |=> SP_O == RAM_FIRST
	) else $error("stack pointer did not wrap to the first location");

	stack_back_a: assert property (
		s_push ##1 s_pop |=> MEM_RDATA_O == $past(PUSH_DATA_I, 2) && MEM_VALID_O
	) else $error("popped byte differs from pushed byte");

	ram_read_a: assert property (
		RAM_RE_I && !RAM_WE_I && !PUSH_I && !POP_I && !SP_WE_I
		|=> MEM_VALID_O && SP_O == $past(SP_O)
	) else $error("direct RAM read gave no answer");

	bank_pick_a: assert property (
		(REG_WE_I || REG_RE_I) && !in_mirror
		|=> PER_BANK_O == $past(q_r.flag[FLAG_BANK_BIT]) && PER_ADDR_O == $past(REG_ADDR_I)
	) else $error("register access went to the wrong bank");

	mirror_bank_a: assert property (
		(REG_WE_I || REG_RE_I) && REG_ADDR_I >= MIRROR_LO && REG_ADDR_I <= MIRROR_HI
		|=> PER_BANK_O == BANK0 && (PER_WE_O || PER_RE_O)
	) else $error("mirrored address did not reach bank 0");

	read_answer_a: assert property (
		s_read_any |=> PER_RE_O ##1 REG_VALID_O && REG_RDATA_O == $past(PER_RDATA_I)
	) else $error("register read gave no answer two cycles on");

	reset_bank_a: assert property (
		boot_r |-> !FLAG_O[FLAG_BANK_BIT] && SP_O == SP_RST
	) else $error("bank bit or stack pointer not cleared after reset");

	flag_hold_a: assert property (
		!FLAG_WE_I |=> FLAG_O == $past(FLAG_O)
	) else $error("flag register changed without a write");

	sequence s_load;
		SP_WE_I;
	endsequence

	sequence s_reg_idle;
		!REG_WE_I && !REG_RE_I;
	endsequence

	sequence s_req;
		REG_WE_I || REG_RE_I;
	endsequence

	// A pointer load wins over every other stack or RAM request.
	sp_load_a: assert property (
		s_load |=> SP_O == $past(SP_WDATA_I)
	) else $error("stack pointer load was lost");

	// A pop steps the pointer down and answers in the next cycle.
	pop_retreat_a: assert property (
		s_pop |=> SP_O == 8'($past(SP_O) - SP_STEP) && MEM_VALID_O
	) else $error("stack pointer did not step down on pop");

	// Popping from the first location leaves the pointer at the top one.
	pop_wrap_a: assert property (
		s_pop and (SP_O == RAM_FIRST) |=> SP_O == RAM_TOP
	) else $error("stack pointer did not wrap down to the top location");

	// Without a stack request the pointer stands still.
	sp_hold_a: assert property (
		!SP_WE_I && !PUSH_I && !POP_I |=> SP_O == $past(SP_O)
	) else $error("stack pointer moved without a request");

	// Only a pop or a direct read raises the answer pulse.
	valid_idle_a: assert property (
		!POP_I && !RAM_RE_I |=> !MEM_VALID_O
	) else $error("RAM answer pulse without a read");

	// A push stores and gives no answer pulse.
	push_quiet_a: assert property (
		s_push |=> !MEM_VALID_O
	) else $error("push raised the RAM answer pulse");

	// A direct write neither answers nor moves the pointer.
	ram_write_a: assert property (
		RAM_WE_I && !SP_WE_I && !PUSH_I && !POP_I |=> !MEM_VALID_O && SP_O == $past(SP_O)
	) else $error("direct RAM write disturbed the stack");

	// A flag write shows up in the next cycle.
	flag_load_a: assert property (
		FLAG_WE_I |=> FLAG_O == $past(FLAG_WDATA_I)
	) else $error("flag register write was lost");

	// A register write reaches the peripherals as a single write pulse.
	write_strobe_a: assert property (
		REG_WE_I |=> PER_WE_O && !PER_RE_O && PER_WDATA_O == $past(REG_WDATA_I)
	) else $error("register write not presented to peripherals");

	// A register read carries no write data.
	read_strobe_a: assert property (
		s_read_any |=> PER_RE_O && !PER_WE_O && PER_WDATA_O == DATA_ZERO
	) else $error("register read not presented to peripherals");

	// With no request both peripheral strobes stay low.
	idle_strobe_a: assert property (
		s_reg_idle |=> !PER_WE_O && !PER_RE_O
	) else $error("peripheral strobe without a request");

	// Address and bank stand until the next request.
	addr_hold_a: assert property (
		s_reg_idle |=> PER_ADDR_O == $past(PER_ADDR_O) && PER_BANK_O == $past(PER_BANK_O)
	) else $error("peripheral address changed without a request");

	// The read answer follows a peripheral read pulse only.
	valid_only_read_a: assert property (
		!PER_RE_O |=> !REG_VALID_O
	) else $error("register answer without a peripheral read");

	// Read data stand until the next read answer.
	rdata_hold_a: assert property (
		!PER_RE_O |=> REG_RDATA_O == $past(REG_RDATA_O)
	) else $error("register read data changed without a read");

	// Known offsets are only flagged for bank 0.
	known_bank_a: assert property (
		PER_KNOWN_O |-> PER_BANK_O == BANK0
	) else $error("known offset flagged outside bank 0");

	// With the bank bit set, addresses outside the mirror go to bank 1.
	bank_one_a: assert property (
		(REG_WE_I || REG_RE_I) && !in_mirror && FLAG_O[FLAG_BANK_BIT] |=> PER_BANK_O
	) else $error("register access missed bank 1");

	// Independent shadow of the pointer, built from the strobe priorities alone.
	logic [DBRD_AW-1:0] sp_model_r;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			sp_model_r <= SP_RST;
		end else if (SP_WE_I) begin
			sp_model_r <= SP_WDATA_I;
		end else if (PUSH_I) begin
			sp_model_r <= sp_model_r + SP_STEP;
		end else if (POP_I) begin
			sp_model_r <= sp_model_r - SP_STEP;
		end
	end

	sp_shadow_a: assert property (
		SP_O == sp_model_r
	) else $error("stack pointer differs from its shadow");
endmodule : dbrd_top
`default_nettype wire

//--- tb/dbrd_per_model.sv
`timescale 1ns/100ps
`default_nettype none
module dbrd_per_model (
	input wire logic clk_i,
	input wire logic bank_i,
	input wire logic [7:0] addr_i,
	input wire logic we_i,
	input wire logic re_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] regs [0:511];
	logic [7:0] last = 8'h00;
	initial begin
		for (int i = 0; i < 512; i++) begin
			regs[i] = i[7:0] ^ {i[8], 7'h2a};
		end
	end
	// Outside a read the bus is released, so it shows the inverse of the last value.
	assign rdata_o = re_i ? regs[{bank_i, addr_i}] : ~last;
	always @(posedge clk_i) begin
		if (we_i) begin
			regs[{bank_i, addr_i}] <= wdata_i;
		end
		if (re_i) begin
			last <= regs[{bank_i, addr_i}];
		end
	end
endmodule : dbrd_per_model
`default_nettype wire

//--- tb/dbrd_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module dbrd_top_tb_top;
	import dbrd_pkg::*;
	logic clk, rst_b, flag_we, sp_we, push_i, pop_i, ram_we, ram_re, reg_we, reg_re;
	logic [7:0] flag_wd, sp_wd, push_d, ram_a, ram_wd, reg_a, reg_wd, per_rd;
	logic [7:0] flag_o, sp_o, mem_rd, reg_rd_o, per_a, per_wd;
	logic mem_v, reg_v, per_bank, per_we, per_re, per_known;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	dbrd_top u_dbrd_top (.CLK_I(clk), .RST_B_I(rst_b), .FLAG_WE_I(flag_we), .FLAG_WDATA_I(flag_wd),
		.FLAG_O(flag_o), .SP_WE_I(sp_we), .SP_WDATA_I(sp_wd), .SP_O(sp_o), .PUSH_I(push_i),
		.PUSH_DATA_I(push_d), .POP_I(pop_i), .RAM_WE_I(ram_we), .RAM_RE_I(ram_re),
		.RAM_ADDR_I(ram_a), .RAM_WDATA_I(ram_wd), .MEM_RDATA_O(mem_rd), .MEM_VALID_O(mem_v),
		.REG_WE_I(reg_we), .REG_RE_I(reg_re), .REG_ADDR_I(reg_a), .REG_WDATA_I(reg_wd),
		.REG_RDATA_O(reg_rd_o), .REG_VALID_O(reg_v), .PER_BANK_O(per_bank), .PER_ADDR_O(per_a),
		.PER_WE_O(per_we), .PER_RE_O(per_re), .PER_WDATA_O(per_wd), .PER_KNOWN_O(per_known),
		.PER_RDATA_I(per_rd));
	dbrd_per_model u_dbrd_per_model (.clk_i(clk), .bank_i(per_bank), .addr_i(per_a),
		.we_i(per_we), .re_i(per_re), .wdata_i(per_wd), .rdata_o(per_rd));
	function automatic logic [7:0] pat(input logic b, input logic [7:0] a);
		return a ^ {b, 7'h2a};
	endfunction : pat
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results
	task automatic push(input logic [7:0] d);
		@(posedge clk);
		push_i <= 1'b1;
		push_d <= d;
		@(posedge clk);
		push_i <= 1'b0;
		#1;
	endtask : push
	task automatic pop(input logic [7:0] exp);
		@(posedge clk);
		pop_i <= 1'b1;
		@(posedge clk);
		pop_i <= 1'b0;
		#1;
		chk({7'h00, mem_v}, 8'h01, "pop valid");
		chk(mem_rd, exp, "pop data");
	endtask : pop
	task automatic ram_op(input logic we, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		ram_we <= we;
		ram_re <= !we;
		ram_a <= a;
		ram_wd <= d;
		@(posedge clk);
		ram_we <= 1'b0;
		ram_re <= 1'b0;
		#1;
		if (!we) begin
			chk({7'h00, mem_v}, 8'h01, "ram valid");
			chk(mem_rd, d, "ram data");
		end
	endtask : ram_op
	task automatic reg_op(input logic we, input logic [7:0] a, input logic [7:0] d, input logic b);
		@(posedge clk);
		reg_we <= we;
		reg_re <= !we;
		reg_a <= a;
		reg_wd <= d;
		@(posedge clk);
		reg_we <= 1'b0;
		reg_re <= 1'b0;
		#1;
		chk({6'h00, per_we, per_re}, {6'h00, we, !we}, "per strobe");
		chk(per_a, a, "per addr");
		chk({7'h00, per_bank}, {7'h00, b}, "per bank");
		if (we) begin
			chk(per_wd, d, "per wdata");
		end else begin
			@(posedge clk);
			#1;
			chk({7'h00, reg_v}, 8'h01, "reg valid");
			chk(reg_rd_o, d, "reg data");
		end
	endtask : reg_op
	task automatic flag_wr(input logic [7:0] v);
		@(posedge clk);
		flag_we <= 1'b1;
		flag_wd <= v;
		@(posedge clk);
		flag_we <= 1'b0;
		#1;
		chk(flag_o, v, "flag");
	endtask : flag_wr
	initial begin
		clk = 1'b0;
		forever begin
			#25 clk = ~clk;
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			results();
		end
	end
	initial begin
		logic [7:0] mir [4] = '{8'h70, 8'h71, 8'h9f, 8'ha0};
		logic b;
		{rst_b, flag_we, sp_we, push_i, pop_i, ram_we, ram_re, reg_we, reg_re} = '0;
		{flag_wd, sp_wd, push_d, ram_a, ram_wd, reg_a, reg_wd} = '0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk(flag_o, FLAG_RST, "flag reset");
		chk(sp_o, SP_RST, "sp reset");
		@(posedge clk);
		sp_we <= 1'b1;
		sp_wd <= 8'hfd;
		@(posedge clk);
		sp_we <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			push(8'ha1 + i[7:0]);
			chk(sp_o, 8'hfe + i[7:0], "sp after push");
		end
		ram_op(1'b0, 8'hff, 8'ha3);
		for (int i = 0; i < 3; i++) begin
			pop(8'ha3 - i[7:0]);
			chk(sp_o, 8'hff - i[7:0], "sp after pop");
		end
		ram_op(1'b1, 8'h00, 8'h5c);
		ram_op(1'b0, 8'h00, 8'h5c);
		reg_op(1'b1, PORT0_PIN_DATA, 8'h3c, 1'b0);
		chk({7'h00, per_known}, 8'h01, "known bank 0");
		reg_op(1'b0, PORT0_PIN_DATA, 8'h3c, 1'b0);
		flag_wr(8'h10);
		reg_op(1'b0, PORT0_PIN_DATA, pat(1'b1, 8'h00), 1'b1);
		chk({7'h00, per_known}, 8'h00, "known bank 1");
		reg_op(1'b1, ANALOG_COL0_BLK10_CTRL1, 8'h47, 1'b0);
		flag_wr(8'h00);
		reg_op(1'b0, ANALOG_COL0_BLK10_CTRL1, 8'h47, 1'b0);
		flag_wr(8'h10);
		foreach (mir[i]) begin
			b = !(mir[i] >= MIRROR_LO && mir[i] <= MIRROR_HI);
			reg_op(1'b0, mir[i], pat(b, mir[i]), b);
		end
		@(posedge clk);
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk(flag_o, FLAG_RST, "flag mid reset");
		chk(sp_o, SP_RST, "sp mid reset");
		reg_op(1'b0, PORT0_PIN_DATA, 8'h3c, 1'b0);
		@(posedge clk);
		push_i <= 1'b1;
		push_d <= 8'h6e;
		@(posedge clk);
		push_i <= 1'b0;
		pop_i <= 1'b1;
		@(posedge clk);
		pop_i <= 1'b0;
		#1;
		chk({7'h00, mem_v}, 8'h01, "push pop valid");
		chk(mem_rd, 8'h6e, "push pop data");
		chk(sp_o, SP_RST, "push pop sp");
		results();
	end
endmodule : dbrd_top_tb_top
`default_nettype wire
